// File: sim/fecs_flash_model.sv
// Purpose: behavioural flash at the far side of the host controller
// Assumes: write taken at strobe rise, read data held 3 cycles after oe_n rise
// Notes: one bank, erase lasts ERASE_CYC cycles, every write is logged
`timescale 1ns/1ns
module fecs_flash_model #(parameter int ERASE_CYC = 300) (
	// clock
	input wire logic clk_i,
	// pins driven by the host
	input wire logic [21:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wdata_oe_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	// pins driven by the flash
	output logic [15:0] rdata_o,
	output logic ready_busy_n_o
);
	logic [37:0] wlog[$];
	logic [7:0] seq[5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
	logic [7:0] d;
	logic [15:0] last = 16'h0000;
	logic we_q = 1'b1;
	logic chip = 1'b0;
	logic susp = 1'b0;
	logic tgl = 1'b0;
	int step = 0;
	int busy = 0;
	int hold = 0;
	////////////////////////////////////////////////////////////////////
	// command decode on the strobe rise
	always @(posedge clk_i) begin
		we_q <= we_n_i;
		if (busy > 0) busy <= busy - 1;
		if (!oe_n_i) begin
			// while erasing: polling bit low, toggle and sector toggle flip per read
			last <= (busy > 0) ? {8'h00, 1'b0, tgl, 2'b00, 1'b1, tgl, 2'b00}
				: addr_i[15:0] ^ 16'hc3c3;
			hold <= 3;
			if (hold == 0) tgl <= ~tgl;
		end else if (hold > 0) hold <= hold - 1;
		if (!we_q && we_n_i) begin
			// a strobe without driven data is logged as unknown
			wlog.push_back({addr_i, wdata_oe_i ? wdata_i : 16'hxxxx});
			d = wdata_oe_i ? wdata_i[7:0] : 8'h00;
			if (busy > 0) begin
				if (!chip && d == 8'hb0) begin
					busy <= 0;
					susp <= 1'b1;
				end
			end else if (susp && d == 8'h30) begin
				busy <= ERASE_CYC;
				susp <= 1'b0;
			end else if (step == 5 && (d == 8'h10 || d == 8'h30)) begin
				busy <= ERASE_CYC;
				chip <= (d == 8'h10);
				step <= 0;
			end else step <= (step < 5 && d == seq[step]) ? step + 1 : 0;
		end
	end
	// after the 3-cycle hold the released bus shows the inverse, never a stale value
	assign rdata_o = (!oe_n_i || hold > 0) ? last : ~last;
	assign ready_busy_n_o = (busy == 0);
endmodule // fecs_flash_model

// File: sim/flash_erase_command_sequencer_test.sv
// Purpose: self-checking bench for the flash erase host controller
// Assumes: zero wait-state slave, flash model logs every write cycle
// Notes: expected writes come from the bench's own sequence table
`timescale 1ns/1ns
module flash_erase_command_sequencer_test;
	logic clk_i = 0, arst_n_i = 0, hsel = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h0d5fbf6a;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hrdata;
	logic hreadyout, hresp, dq_oe, we_n, oe_n, rb_n;
	logic [21:0] fa, a;
	logic [15:0] dq_o, dq_i;
	int fail_count = 0, num_checks = 0, n;
	fecs_host DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.fl_addr_o(fa), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_i), .fl_we_n_o(we_n),
		.fl_oe_n_o(oe_n), .ready_busy_n_i(rb_n));
	fecs_flash_model M (.clk_i(clk_i), .addr_i(fa), .wdata_i(dq_o), .wdata_oe_i(dq_oe),
		.we_n_i(we_n), .oe_n_i(oe_n), .rdata_o(dq_i), .ready_busy_n_o(rb_n));
	always #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// one single transfer; data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		haddr <= {24'h000000, ad};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk_i);
		while (hreadyout !== 1'b1) @(posedge clk_i);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk_i);
		while (hreadyout !== 1'b1) @(posedge clk_i);
		// data phase value, taken at the edge that closes the data phase
		rd = hrdata;
		chk(hresp === 1'b0, "error response");
	endtask
	// issue one op and wait for the sequencer to go idle
	task automatic op(input logic [3:0] c, input logic [21:0] ta);
		ahb(1, 8'h04, {10'h000, ta});
		ahb(1, 8'h00, {27'h0000000, 1'b1, c});
		n = 0;
		do begin
			ahb(0, 8'h08, 32'h0);
			n++;
		end while (rd[2] !== 1'b0 && n < 5000);
		chk(n < 5000, "sequencer stuck busy");
	endtask
	task automatic exp_w(input logic [21:0] ea, input logic [7:0] ed);
		logic [37:0] g;
		g = (M.wlog.size() > 0) ? M.wlog.pop_front() : 'x;
		chk(g === {ea, 8'h00, ed}, $sformatf("write %h want %h %h", g, ea, ed));
	endtask
	task automatic erase6(input logic [21:0] la, input logic [7:0] ld);
		exp_w(22'h000555, 8'haa);
		exp_w(22'h0002aa, 8'h55);
		exp_w(22'h000555, 8'h80);
		exp_w(22'h000555, 8'haa);
		exp_w(22'h0002aa, 8'h55);
		exp_w(la, ld);
	endtask
	// poll the synced ready line until it reads v
	task automatic wait_rb(input logic v);
		n = 0;
		do begin
			ahb(0, 8'h08, 32'h0);
			n++;
		end while (rd[3] !== v && n < 2000);
		chk(n < 2000, "ready line wait");
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs just over a thousand cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1;
		@(posedge clk_i);
		op(4'h1, 22'h000000);
		erase6(22'h000555, 8'h10);
		wait_rb(1'b0);
		op(4'h4, 22'h380000);
		exp_w(22'h380000, 8'hb0);
		ahb(0, 8'h08, 32'h0);
		chk(rd[3] === 1'b0, "suspend during chip erase");
		wait_rb(1'b1);
		$display("test chip erase done");
		a = 22'(rnd());
		op(4'h2, a);
		erase6(a & 22'h3ff000, 8'h30);
		ahb(0, 8'h08, 32'h0);
		chk(rd[4] === 1'b1, "window not running");
		a = 22'(rnd());
		op(4'h3, a);
		exp_w(a & 22'h3ff000, 8'h30);
		op(4'h4, a);
		exp_w(a & 22'h380000, 8'hb0);
		ahb(0, 8'h08, 32'h0);
		chk(rd[4] === 1'b0, "window kept after suspend");
		wait_rb(1'b1);
		a = 22'(rnd());
		op(4'h7, a);
		ahb(0, 8'h0c, 32'h0);
		chk(rd[15:0] === (a[15:0] ^ 16'hc3c3), "read data");
		op(4'h5, a);
		exp_w(a & 22'h380000, 8'h30);
		wait_rb(1'b0);
		wait_rb(1'b1);
		$display("test sector erase done");
		op(4'h0, 22'h000000);
		chk(M.wlog.size() == 0, "empty order wrote");
		op(4'h6, 22'h000000);
		chk(M.wlog.size() > 0 && M.wlog[0][7:0] === 8'hf0, "reset code");
		$display("test reset done");
		// host reset in mid-sequence, then the whole erase once more
		ahb(1, 8'h00, 32'h00000011);
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b0;
		@(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		ahb(0, 8'h08, 32'h0);
		chk(rd[2] === 1'b0 && we_n === 1'b1, "reset did not abort");
		op(4'h6, 22'h000000);
		M.wlog.delete();
		op(4'h1, 22'h000000);
		erase6(22'h000555, 8'h10);
		wait_rb(1'b0);
		wait_rb(1'b1);
		$display("test reset abort done");
		give_verdict();
	end
endmodule // flash_erase_command_sequencer_test

// File: verilog/fecs_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write strobe or read sample
// Assumes: pins registered here, read data already resynchronised by caller
// Notes: write data latched by the flash on the rising edge of the strobe
`timescale 1ns/1ns
`include "fecs_regs.svh"
module fecs_bus_cycle
	import fecs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// request side
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [21:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic done_o,
	// flash pins
	output logic [21:0] fl_addr_o,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe_o,
	output logic fl_we_n_o,
	output logic fl_oe_n_o
);
	logic [7:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic [21:0] addr_q, addr_d;
	logic [15:0] dq_q, dq_d;
	logic wr_q, wr_d;
	logic strobe_q, strobe_d;
	logic [7:0] len;

	////////////////////////////////////////////////////////////////
	// cycle timing: strobe low for the whole count, then one idle cycle
	always_comb begin
		len = write_i ? 8'(`FECS_WE_LOW_CYC) : 8'(`FECS_RD_CYC);
		cnt_d = cnt_q;
		busy_d = busy_q;
		addr_d = addr_q;
		dq_d = dq_q;
		wr_d = wr_q;
		strobe_d = strobe_q;
		done_o = 1'b0;
		if (!busy_q) begin
			if (start_i) begin
				busy_d = 1'b1;
				cnt_d = len;
				addr_d = addr_i;
				dq_d = {8'h00, wdata_i}; // upper byte ignored by flash, drive zero
				wr_d = write_i;
				strobe_d = 1'b1;
			end
		end else if (cnt_q != 8'h00) begin
			cnt_d = cnt_q - 8'h01;
			if (cnt_q == 8'h01) begin
				strobe_d = 1'b0; // rising strobe edge latches data
			end
		end else begin
			busy_d = 1'b0;
			done_o = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			addr_q <= `FECS_ADDR_RST;
			dq_q <= 16'h0000;
			wr_q <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			wr_q <= wr_d;
			strobe_q <= strobe_d;
		end
	end

	// data stays driven through the idle cycle for hold time
	assign fl_addr_o = addr_q;
	assign fl_dq_o = dq_q;
	assign fl_dq_oe_o = busy_q & wr_q;
	assign fl_we_n_o = ~(strobe_q & wr_q);
	assign fl_oe_n_o = ~(strobe_q & ~wr_q);

	property p_strobe_len;
		@(posedge clk_i) disable iff (!arst_n_i)
		(start_i && !busy_q && write_i) |=> !fl_we_n_o [*3] ##1 fl_we_n_o;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("write strobe length wrong");
endmodule // fecs_bus_cycle

// File: verilog/fecs_host.sv
// Purpose: host controller issuing erase, suspend and resume sequences to a NOR flash
// Assumes: AHB-Lite single word transfers, one flash device, 50 MHz clock
// Notes: the controller pre-masks command addresses to bank or sector bits; reads use the full address
// Contract
// - chip erase is six writes: two unlocks, setup, two unlocks, chip erase code
// - hardware reset aborts erase; host reissues full sequence afterwards
// - sector erase is six writes, last carries sector address and erase code
// - host spaces additional sector writes less than 80 us apart
// - host should keep interrupts off while loading extra sectors
// - other command in window resets bank; host rewrites the sequence
// - suspend code b0 with bank address, valid only in sector erase
// - resume code with bank address restarts erase; extra resumes ignored
// - sector address taken from sector select bits 21 to 12
// - bank address taken from bank select bits 21 to 19
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "fecs_regs.svh"
module fecs_host
	import fecs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// flash pins
	output logic [21:0] fl_addr_o,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe_o,
	input wire logic [15:0] fl_dq_i,
	output logic fl_we_n_o,
	output logic fl_oe_n_o,
	input wire logic ready_busy_n_i
);
	fecs_state_type st_q, st_d;
	logic [3:0] op_q, op_d;
	logic [21:0] addr_q, addr_d;
	logic [2:0] step_q, step_d;
	logic [2:0] last_q, last_d;
	logic [31:0] win_q, win_d;
	logic [15:0] rdata_q, rdata_d;
	logic ap_wr_q, ap_wr_d;
	logic [7:0] ap_off_q, ap_off_d;
	logic [1:0] rb_sync_q;
	logic [15:0] dq_s1_q, dq_s2_q;
	logic cyc_start, cyc_write, cyc_done, go;
	logic [21:0] cyc_addr;
	logic [7:0] cyc_data;
	logic ready_busy_n;

	////////////////////////////////////////////////////////////////
	// pin synchronisers, first stage read only by the second
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rb_sync_q <= 2'b00;
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			rb_sync_q <= {rb_sync_q[0], ready_busy_n_i};
			dq_s1_q <= fl_dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end
	assign ready_busy_n = rb_sync_q[1];

	////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign go = ap_wr_q && ap_off_q == `FECS_OFF_CMD && hwdata_i[`FECS_CMD_GO_BIT]
		&& st_q == FECS_ST_IDLE;
	always_comb begin
		ap_wr_d = hsel_i && hready_i && htrans_i[1] && hwrite_i;
		ap_off_d = haddr_i[7:0];
		case (ap_off_q)
			`FECS_OFF_ADDR: hrdata_o = {10'h000, addr_q};
			`FECS_OFF_STAT: hrdata_o = {24'h000000, 3'h0,
				win_q != 32'h0, ready_busy_n, st_q != FECS_ST_IDLE, 2'h0};
			`FECS_OFF_RDATA: hrdata_o = {16'h0000, rdata_q};
			default: hrdata_o = {28'h0000000, op_q};
		endcase
	end

	////////////////////////////////////////////////////////////////
	// command sequencer; step counts the six-write erase frames
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		step_d = step_q;
		last_d = last_q;
		rdata_d = rdata_q;
		win_d = (win_q != 32'h0) ? win_q - 32'h1 : 32'h0; // mirror of the flash window
		cyc_start = 1'b0;
		cyc_write = 1'b1;
		cyc_addr = `FECS_UNLOCK1_ADDR;
		cyc_data = `FECS_UNLOCK1_DATA;
		if (ap_wr_q && ap_off_q == `FECS_OFF_ADDR && st_q == FECS_ST_IDLE) begin
			addr_d = hwdata_i[21:0];
		end
		case (st_q)
			FECS_ST_IDLE: begin
				if (go) begin
					op_d = hwdata_i[3:0];
					step_d = 3'h0;
					st_d = FECS_ST_LOAD;
					case (fecs_op_type'(hwdata_i[3:0]))
						FECS_OP_CHIP_ERASE, FECS_OP_SECTOR_ERASE: last_d = 3'h5;
						FECS_OP_NONE: st_d = FECS_ST_IDLE;
						default: last_d = 3'h0; // single-cycle orders
					endcase
				end
			end
			FECS_ST_LOAD: begin
				cyc_start = 1'b1;
				st_d = FECS_ST_STROBE;
			end
			FECS_ST_STROBE: begin
				if (cyc_done) begin
					if (step_q == last_q) begin
						st_d = FECS_ST_IDLE;
						if (op_q == FECS_OP_SECTOR_ERASE || op_q == FECS_OP_ADD_SECTOR) begin
							win_d = 32'(`FECS_WINDOW_CYC);
						end
						if (op_q == FECS_OP_SUSPEND) begin
							win_d = 32'h0;
						end
						if (op_q == FECS_OP_READ) begin
							st_d = FECS_ST_READ;
						end
					end else begin
						step_d = step_q + 3'h1;
						st_d = FECS_ST_LOAD;
					end
				end
			end
			FECS_ST_READ: begin
				rdata_d = dq_s2_q; // two-stage resynced read data
				st_d = FECS_ST_IDLE;
			end
			default: st_d = FECS_ST_IDLE;
		endcase
		// address and data of the current bus cycle
		case (step_q)
			3'h1, 3'h4: begin
				cyc_addr = `FECS_UNLOCK2_ADDR;
				cyc_data = `FECS_UNLOCK2_DATA;
			end
			3'h2: cyc_data = `FECS_SETUP_DATA;
			3'h5: begin
				if (op_q == FECS_OP_CHIP_ERASE) begin
					cyc_data = `FECS_CHIP_DATA;
				end else begin
					cyc_addr = addr_q & `FECS_SECTOR_MASK;
					cyc_data = `FECS_SECTOR_DATA;
				end
			end
			default: begin
				case (fecs_op_type'(op_q))
					FECS_OP_ADD_SECTOR: begin
						cyc_addr = addr_q & `FECS_SECTOR_MASK;
						cyc_data = `FECS_SECTOR_DATA;
					end
					FECS_OP_SUSPEND: begin
						cyc_addr = addr_q & `FECS_BANK_MASK;
						cyc_data = `FECS_SUSPEND_DATA;
					end
					FECS_OP_RESUME: begin
						cyc_addr = addr_q & `FECS_BANK_MASK;
						cyc_data = `FECS_RESUME_DATA;
					end
					FECS_OP_RESET: cyc_data = `FECS_RESET_DATA;
					FECS_OP_READ: begin
						cyc_addr = addr_q;
						cyc_write = 1'b0;
					end
					default: ;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= FECS_ST_IDLE;
			op_q <= 4'h0;
			addr_q <= `FECS_ADDR_RST;
			step_q <= 3'h0;
			last_q <= 3'h0;
			win_q <= 32'h0;
			rdata_q <= 16'h0000;
			ap_wr_q <= 1'b0;
			ap_off_q <= 8'h00;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			step_q <= step_d;
			last_q <= last_d;
			win_q <= win_d;
			rdata_q <= rdata_d;
			ap_wr_q <= ap_wr_d;
			ap_off_q <= ap_off_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// one bus cycle at a time; upper byte driven zero
	fecs_bus_cycle u_cycle (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.start_i(cyc_start),
		.write_i(cyc_write),
		.addr_i(cyc_addr),
		.wdata_i(cyc_data),
		.done_o(cyc_done),
		.fl_addr_o(fl_addr_o),
		.fl_dq_o(fl_dq_o),
		.fl_dq_oe_o(fl_dq_oe_o),
		.fl_we_n_o(fl_we_n_o),
		.fl_oe_n_o(fl_oe_n_o)
	);

	////////////////////////////////////////////////////////////////
	sequence s_sixth_write;
		st_q == FECS_ST_STROBE && cyc_done && step_q == 3'h5;
	endsequence
	property p_six_cycles;
		@(posedge clk_i) disable iff (!arst_n_i)
		s_sixth_write |=> st_q == FECS_ST_IDLE;
	endproperty
	a_six_cycles: assert property (p_six_cycles) else $error("erase frame not six");
	property p_window_start;
		@(posedge clk_i) disable iff (!arst_n_i)
		(s_sixth_write and op_q == FECS_OP_SECTOR_ERASE) |=> win_q == 32'(`FECS_WINDOW_CYC);
	endproperty
	a_window_start: assert property (p_window_start) else $error("window not armed");
	property p_suspend_code;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cyc_start && op_q == FECS_OP_SUSPEND) |=> fl_dq_o[7:0] == 8'hb0
			&& (fl_addr_o & ~`FECS_BANK_MASK) == 22'h0;
	endproperty
	a_suspend_code: assert property (p_suspend_code) else $error("bad suspend");
	property p_sector_addr;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cyc_start && step_q == 3'h5 && op_q == FECS_OP_SECTOR_ERASE) |=>
			fl_addr_o[11:0] == 12'h000 && fl_dq_o[7:0] == 8'h30;
	endproperty
	a_sector_addr: assert property (p_sector_addr) else $error("bad sector write");
	property p_unlock;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cyc_start && step_q == 3'h1) |=> fl_addr_o == 22'h2aa && fl_dq_o == 16'h0055;
	endproperty
	a_unlock: assert property (p_unlock) else $error("bad second unlock");
	property p_upper_zero;
		@(posedge clk_i) disable iff (!arst_n_i)
		!fl_dq_oe_o || fl_dq_o[15:8] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper byte driven");
	property p_resume_bank;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cyc_start && op_q == FECS_OP_RESUME) |=> fl_dq_o[7:0] == 8'h30
			&& fl_addr_o[18:0] == 19'h0;
	endproperty
	a_resume_bank: assert property (p_resume_bank) else $error("bad resume");
	property p_chip_code;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cyc_start && step_q == 3'h5 && op_q == FECS_OP_CHIP_ERASE) |=>
			fl_dq_o[7:0] == 8'h10 && fl_addr_o == 22'h555;
	endproperty
	a_chip_code: assert property (p_chip_code) else $error("bad chip erase");
endmodule // fecs_host

// File: verilog/fecs_pkg.sv
// Purpose: types for the flash erase command sequencer host controller
// Assumes: nothing beyond the header constants
// Notes: op codes are written by software into the command register
package fecs_pkg;
	typedef enum logic [3:0] {
		FECS_OP_NONE,
		FECS_OP_CHIP_ERASE,
		FECS_OP_SECTOR_ERASE,
		FECS_OP_ADD_SECTOR,
		FECS_OP_SUSPEND,
		FECS_OP_RESUME,
		FECS_OP_RESET,
		FECS_OP_READ
	} fecs_op_type;
	typedef enum logic [2:0] {
		FECS_ST_IDLE,
		FECS_ST_LOAD,
		FECS_ST_STROBE,
		FECS_ST_RECOVER,
		FECS_ST_READ
	} fecs_state_type;
endpackage

// File: verilog/fecs_regs.svh
// Purpose: constants for the flash erase command sequencer host controller
// Assumes: 50 MHz clock, AHB-Lite register port, 32-bit words
// Notes: offsets are byte addresses of the controller's own registers
`ifndef FECS_REGS_SVH
`define FECS_REGS_SVH
`define FECS_OFF_CMD 8'h00
`define FECS_OFF_ADDR 8'h04
`define FECS_OFF_STAT 8'h08
`define FECS_OFF_RDATA 8'h0c
`define FECS_CMD_OP_LSB 0
`define FECS_CMD_GO_BIT 4
`define FECS_ADDR_RST 22'h000000
`define FECS_UNLOCK1_ADDR 22'h000555
`define FECS_UNLOCK2_ADDR 22'h0002aa
`define FECS_UNLOCK1_DATA 8'haa
`define FECS_UNLOCK2_DATA 8'h55
`define FECS_SETUP_DATA 8'h80
`define FECS_CHIP_DATA 8'h10
`define FECS_SECTOR_DATA 8'h30
`define FECS_RESUME_DATA 8'h30
`define FECS_SUSPEND_DATA 8'hb0
`define FECS_RESET_DATA 8'hf0
`define FECS_BANK_MASK 22'h380000
`define FECS_SECTOR_MASK 22'h3ff000
`define FECS_CLK_MHZ 50
`define FECS_WE_LOW_NS 60
`define FECS_WE_LOW_CYC ((`FECS_WE_LOW_NS * `FECS_CLK_MHZ + 999) / 1000)
`define FECS_RD_NS 100
`define FECS_RD_CYC ((`FECS_RD_NS * `FECS_CLK_MHZ + 999) / 1000)
`define FECS_WINDOW_US 80
`define FECS_WINDOW_CYC (`FECS_WINDOW_US * `FECS_CLK_MHZ)
`endif
